// ### rtl/pdr_pkg.sv
package pdr_pkg;

    // ==================================================================
    // Register indices (printed offsets, byte address is index times 4)
    localparam logic [9:0] PDR_IDX_BACKOFF = 10'h0ae;
    localparam logic [9:0] PDR_IDX_REGULATOR = 10'h0d0;
    localparam logic [9:0] PDR_IDX_LINE_DIAG = 10'h155;
    localparam logic [9:0] PDR_IDX_DIAG_MAIN = 10'h170;
    localparam logic [9:0] PDR_IDX_DIAG_PULSE = 10'h171;
    localparam logic [9:0] PDR_IDX_DIAG_LENGTH = 10'h173;
    localparam logic [9:0] PDR_IDX_DIAG_THRESH = 10'h177;
    localparam logic [9:0] PDR_IDX_DIAG_STATUS = 10'h178;

    // ==================================================================
    // Field positions
    localparam int PDR_BACKOFF_LSB = 6;
    localparam int PDR_REG_PD_BIT = 15;
    localparam int PDR_LD_START_BIT = 15;
    localparam int PDR_LD_TX_BYP_BIT = 12;
    localparam int PDR_LD_OUT_LSB = 4;
    localparam int PDR_DM_CROSS_BIT = 14;
    localparam int PDR_DM_TX_BYP_BIT = 13;
    localparam int PDR_DM_RX_BYP_BIT = 12;
    localparam int PDR_DM_RSVD_BIT = 11;
    localparam int PDR_DM_AVG_LSB = 8;
    localparam int PDR_DS_DONE_BIT = 1;
    localparam int PDR_DS_BUSY_BIT = 0;

    // ==================================================================
    // Reset values of the stored fields, fixed read patterns, the reserved depth code and the highest back-off code
    localparam logic [2:0] PDR_BACKOFF_RST = 3'h0;
    localparam logic [15:0] PDR_BACKOFF_FIXED = 16'h8020;
    localparam logic [2:0] PDR_LD_AVG_RST = 3'h1;
    localparam logic [2:0] PDR_DM_AVG_RST = 3'h6;
    localparam logic [2:0] PDR_DM_AVG_RSVD = 3'h7;
    localparam logic [11:0] PDR_PULSE_HI_RST = 12'hc85;
    localparam logic [3:0] PDR_PULSE_RST = 4'hc;
    localparam logic [7:0] PDR_LENGTH_RST = 8'hff;
    localparam logic [7:0] PDR_LENGTH_LO_RST = 8'hff;
    localparam logic [2:0] PDR_THRESH_HI_RST = 3'h0;
    localparam logic [4:0] PDR_THRESH_RST = 5'h18;
    localparam logic [7:0] PDR_THRESH_LO_RST = 8'h96;
    localparam logic [2:0] PDR_BACKOFF_MAX = 3'h3;

    // AXI responses
    localparam logic [1:0] PDR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PDR_RESP_SLVERR = 2'h2;

    // Configuration handed to the analog reflectometry engine
    typedef struct packed {
        logic cross_en;
        logic tx_bypass;
        logic [2:0] avg_depth;
        logic [2:0] avg_factor;
        logic [3:0] pulse_level;
        logic [7:0] listen_len;
        logic [4:0] short_cable_threshold;
    } pdr_diag_cfg_t;

    // Results returned from the engine
    typedef struct packed {
        logic done;
        logic [7:0] line_diag_result_field;
    } pdr_diag_res_t;

endpackage

// ### rtl/pdr_diag_seq.sv
`timescale 1ns/1ns
// Sequencer around the analog engine: one launch per start request made while no run is in flight
module pdr_diag_seq
    import pdr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic tx_bypass,
    input wire logic engine_done,
    output logic engine_start,
    output logic busy,
    output logic done,
    output logic tx_skipped,
    output logic results_to_rx_slots
);

    typedef enum logic [1:0] {PDR_IDLE, PDR_RUN, PDR_DONE} pdr_seq_state_t;

    pdr_seq_state_t state_q, state_d;
    logic byp_q;

    // ==================================================================
    // Next state: a start while running is dropped, the run in flight wins
    always_comb begin
        state_d = state_q;
        case (state_q)
            PDR_IDLE: if (start) state_d = PDR_RUN;
            PDR_RUN: if (engine_done) state_d = PDR_DONE;
            PDR_DONE: if (start) state_d = PDR_RUN;
            default: state_d = PDR_IDLE;
        endcase
    end

    // State and the bypass choice latched at launch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= PDR_IDLE;
            byp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (start && state_q != PDR_RUN) byp_q <= tx_bypass;
        end
    end

    assign engine_start = start && (state_q != PDR_RUN);
    assign busy = (state_q == PDR_RUN);
    assign done = (state_q == PDR_DONE);
    assign tx_skipped = byp_q;
    assign results_to_rx_slots = byp_q;

endmodule // pdr_diag_seq

// ### rtl/pdr_regs.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
// Notes on behaviour
// - Back-off code 0 normal, 1-3 reduced levels
// - Regulator power-down bit pulses, then self-clears
// - Regulator stays powered while bit is zero
// - Averaging factor field, reset 001
// - Read-only bit reports transmit pair bypassed
// - Cross-disable one forces regular per-pair mode
// - Cross mode listens on opposite pair
// - Transmit-pair bypass bit skips that pair
// - Bypassed transmit results go to receive slots (the sequencer's results_to_rx_slots flag is left unconnected here)
// - Receive-pair bypass read-only, reads zero
// - Averaging depth 2^code, 111 reserved, reset 110
// - Pulse level field, reset 1100
// - Listening length field, reset all ones
// - Short-cable threshold field, reset 11000
// - Read-only reserved bits ignore writes, read zero
module pdr_regs
    import pdr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] backoff_level,
    output logic regulator_powerdown_bit,
    output logic regulator_enable,
    output pdr_diag_cfg_t diag_cfg,
    output logic diag_start,
    input pdr_diag_res_t diag_res
);

    // ==================================================================
    // Decode helpers
    function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] a);
        word_index = 10'(a >> 2);
    endfunction

    function automatic logic known(input logic [9:0] i);
        known = (i == PDR_IDX_BACKOFF) || (i == PDR_IDX_REGULATOR) ||
                (i == PDR_IDX_LINE_DIAG) || (i == PDR_IDX_DIAG_MAIN) ||
                (i == PDR_IDX_DIAG_PULSE) || (i == PDR_IDX_DIAG_LENGTH) ||
                (i == PDR_IDX_DIAG_THRESH) || (i == PDR_IDX_DIAG_STATUS);
    endfunction

    // ==================================================================
    // Write channel capture: address and data taken in either order
    logic aw_held_q, w_held_q, bvalid_q, bad_w_q;
    logic [9:0] aw_idx_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_q || aw_fire;
    wire w_have = w_held_q || w_fire;
    wire wr_go = aw_have && w_have && !bvalid_q;
    wire [9:0] wr_idx = aw_held_q ? aw_idx_q : word_index(s_axi_awaddr);
    wire [15:0] wr_data = w_held_q ? wdata_q : s_axi_wdata[15:0];
    wire [1:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb[1:0];
    wire [15:0] wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            bad_w_q <= 1'b0;
            aw_idx_q <= 10'h000;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
        end else begin
            if (aw_fire) aw_idx_q <= word_index(s_axi_awaddr);
            if (w_fire) begin
                wdata_q <= s_axi_wdata[15:0];
                wstrb_q <= s_axi_wstrb[1:0];
            end
            aw_held_q <= aw_have && !wr_go;
            w_held_q <= w_have && !wr_go;
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bad_w_q <= !known(wr_idx);
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bad_w_q ? PDR_RESP_SLVERR : PDR_RESP_OKAY;

    // Merge of stored value with strobed write data
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    wire [15:0] wr_bits = merge(16'h0000, wr_data, wr_mask);
    wire wr_backoff = wr_go && wr_idx == PDR_IDX_BACKOFF;
    wire wr_reg = wr_go && wr_idx == PDR_IDX_REGULATOR;
    wire wr_ld = wr_go && wr_idx == PDR_IDX_LINE_DIAG;
    wire wr_dm = wr_go && wr_idx == PDR_IDX_DIAG_MAIN;
    wire wr_pulse = wr_go && wr_idx == PDR_IDX_DIAG_PULSE;
    wire wr_len = wr_go && wr_idx == PDR_IDX_DIAG_LENGTH;
    wire wr_thr = wr_go && wr_idx == PDR_IDX_DIAG_THRESH;

    // ==================================================================
    // Stored fields
    logic [2:0] backoff_q;
    logic reg_pd_q;
    logic [14:0] reg_rsvd_q;
    logic [2:0] ld_avg_q;
    logic start_q;
    logic cross_dis_q, tx_byp_q, dm_rsvd_q;
    logic [2:0] avg_depth_q;
    logic [15:0] pulse_q, len_q, thr_q;

    // Byte-lane aware next values of the full-width read-write registers
    wire [15:0] pulse_d = merge(pulse_q, wr_data, wr_mask);
    wire [15:0] len_d = merge(len_q, wr_data, wr_mask);
    wire [15:0] thr_d = merge(thr_q, wr_data, wr_mask);
    wire [14:0] reg_rsvd_d = 15'(merge({1'b0, reg_rsvd_q}, wr_data, wr_mask));
    wire [2:0] backoff_w = 3'(wr_bits >> PDR_BACKOFF_LSB);
    wire [2:0] avg_w = 3'(wr_bits >> PDR_DM_AVG_LSB);

    // Back-off and regulator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            backoff_q <= PDR_BACKOFF_RST;
            reg_pd_q <= 1'b0;
            reg_rsvd_q <= 15'h0000;
        end else begin
            // Reserved codes are refused so the analog side never sees them
            if (wr_backoff && wr_mask[PDR_BACKOFF_LSB + 2] && backoff_w <= PDR_BACKOFF_MAX)
                backoff_q <= backoff_w;
            // One-cycle power-down request, cleared once issued
            reg_pd_q <= wr_reg && wr_bits[PDR_REG_PD_BIT];
            if (wr_reg) reg_rsvd_q <= reg_rsvd_d;
        end
    end

    // Diagnostic control fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ld_avg_q <= PDR_LD_AVG_RST;
            start_q <= 1'b0;
            cross_dis_q <= 1'b0;
            tx_byp_q <= 1'b0;
            dm_rsvd_q <= 1'b1;
            avg_depth_q <= PDR_DM_AVG_RST;
            pulse_q <= {PDR_PULSE_HI_RST, PDR_PULSE_RST};
            len_q <= {PDR_LENGTH_RST, PDR_LENGTH_LO_RST};
            thr_q <= {PDR_THRESH_HI_RST, PDR_THRESH_RST, PDR_THRESH_LO_RST};
        end else begin
            if (wr_ld && wr_strb[0]) ld_avg_q <= wr_bits[2:0];
            start_q <= wr_ld && wr_bits[PDR_LD_START_BIT];
            if (wr_dm && wr_strb[1]) begin
                cross_dis_q <= wr_bits[PDR_DM_CROSS_BIT];
                tx_byp_q <= wr_bits[PDR_DM_TX_BYP_BIT];
                dm_rsvd_q <= wr_bits[PDR_DM_RSVD_BIT];
                if (avg_w != PDR_DM_AVG_RSVD) avg_depth_q <= avg_w;
            end
            if (wr_pulse) pulse_q <= pulse_d;
            if (wr_len) len_q <= len_d;
            if (wr_thr) thr_q <= thr_d;
        end
    end

    // ==================================================================
    // Sequencer for the reflectometry run
    logic seq_busy, seq_done, seq_skipped;

    pdr_diag_seq u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start_q),
        .tx_bypass(tx_byp_q),
        .engine_done(diag_res.done),
        .engine_start(diag_start),
        .busy(seq_busy),
        .done(seq_done),
        .tx_skipped(seq_skipped),
        .results_to_rx_slots()
    );

    // Outputs to the analog side
    assign backoff_level = backoff_q;
    assign regulator_powerdown_bit = reg_pd_q;
    // The power-down event is held by the regulator itself; here only the one-cycle pulse, inverted
    assign regulator_enable = !reg_pd_q;
    assign diag_cfg.cross_en = !cross_dis_q;
    assign diag_cfg.tx_bypass = tx_byp_q;
    assign diag_cfg.avg_depth = avg_depth_q;
    assign diag_cfg.avg_factor = ld_avg_q;
    assign diag_cfg.pulse_level = pulse_q[3:0];
    assign diag_cfg.listen_len = len_q[15:8];
    assign diag_cfg.short_cable_threshold = thr_q[12:8];

    // ==================================================================
    // Read path; read-only reserved bits are tied to zero
    wire [9:0] rd_idx = word_index(s_axi_araddr);
    wire [15:0] rd_ld = {1'b0, 2'b00, seq_skipped, diag_res.line_diag_result_field,
                         1'b0, ld_avg_q};
    wire [15:0] rd_dm = {1'b0, cross_dis_q, tx_byp_q, 1'b0, dm_rsvd_q, avg_depth_q,
                         8'h00};
    wire [15:0] rd_st = {14'h0000, seq_done, seq_busy};
    logic [15:0] rd_mux;

    always_comb begin
        case (rd_idx)
            PDR_IDX_BACKOFF: rd_mux = PDR_BACKOFF_FIXED | {7'h00, backoff_q, 6'h00};
            PDR_IDX_REGULATOR: rd_mux = {1'b0, reg_rsvd_q};
            PDR_IDX_LINE_DIAG: rd_mux = rd_ld;
            PDR_IDX_DIAG_MAIN: rd_mux = rd_dm;
            PDR_IDX_DIAG_PULSE: rd_mux = pulse_q;
            PDR_IDX_DIAG_LENGTH: rd_mux = len_q;
            PDR_IDX_DIAG_THRESH: rd_mux = thr_q;
            PDR_IDX_DIAG_STATUS: rd_mux = rd_st;
            default: rd_mux = 16'h0000;
        endcase
    end

    logic rvalid_q, rbad_q;
    logic [15:0] rdata_q;
    assign s_axi_arready = !rvalid_q;

    // Read answer registered one cycle after address acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rbad_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rbad_q <= !known(rd_idx);
            rdata_q <= rd_mux;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = {16'h0000, rdata_q};
    assign s_axi_rresp = rbad_q ? PDR_RESP_SLVERR : PDR_RESP_OKAY;

endmodule // pdr_regs

// ### tb/pdr_regs_sva.sv
`timescale 1ns/1ns
// ==========================================
// Port checker for the register block
module pdr_regs_sva
    import pdr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] backoff_level,
    input wire logic regulator_powerdown_bit,
    input wire logic regulator_enable,
    input wire pdr_diag_cfg_t diag_cfg,
    input wire logic diag_start
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Steps of the bus transfers
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    // Response timing, read hold, legal codes, one-cycle pulses, and stored fields moving only on a write response
    a_write_resp: assert property (s_wr_take |=> s_axi_bvalid) else $error("bvalid late");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid late");
    a_read_hold: assert property (s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_backoff_legal: assert property (backoff_level <= PDR_BACKOFF_MAX)
        else $error("backoff code reserved");
    a_backoff_cause: assert property (!$stable(backoff_level) |-> $rose(s_axi_bvalid))
        else $error("backoff moved without write");
    a_pd_pulse: assert property ($rose(regulator_powerdown_bit) |->
        $rose(s_axi_bvalid) ##1 !regulator_powerdown_bit) else $error("powerdown not one pulse");
    a_reg_enable: assert property (regulator_enable == !regulator_powerdown_bit)
        else $error("regulator enable wrong");
    a_depth_legal: assert property (diag_cfg.avg_depth != PDR_DM_AVG_RSVD)
        else $error("depth code reserved");
    a_cfg_cause: assert property (!$stable(diag_cfg) |-> $rose(s_axi_bvalid))
        else $error("config moved without write");
    a_start_once: assert property (diag_start |-> s_axi_bvalid ##1 !diag_start)
        else $error("start not one pulse");
endmodule // pdr_regs_sva

// ### tb/phy_power_and_cable_diag_regs_tb.sv
`timescale 1ns/1ns
// ==========================================
// Directed register bench over the bus
module phy_power_and_cable_diag_regs_tb
    import pdr_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] backoff_level;
    logic regulator_powerdown_bit, regulator_enable, diag_start;
    pdr_diag_cfg_t diag_cfg;
    pdr_diag_res_t diag_res = '0;
    int fail_count = 0, checks_done = 0, pd_cnt = 0, st_cnt = 0, off_cnt = 0;

    pdr_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .backoff_level,
        .regulator_powerdown_bit, .regulator_enable, .diag_cfg, .diag_start, .diag_res);

    initial begin
        forever #25 aclk = ~aclk;
    end
    // Pulse counters, so a stuck or doubled pulse shows up
    always @(posedge aclk) begin
        if (regulator_powerdown_bit === 1'b1) pd_cnt++;
        if (regulator_enable === 1'b0) off_cnt++;
        if (diag_start === 1'b1) st_cnt++;
    end

    // ==========================================
    // Compare and bus tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Handshakes are judged at the falling edge; readies only move on rising edges
    task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er = 2'h0);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] rsp;
        b_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_ok) begin
            @(negedge aclk);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            b_ok = s_axi_bvalid && s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk_resp("bresp", er, rsp);
    endtask
    // Ready is raised late on purpose so the slave has to hold its answer
    task automatic rd(input logic [9:0] idx, input logic [15:0] e, input logic [1:0] er = 2'h0);
        logic ar_ok, r_ok, v;
        logic [31:0] dat;
        logic [1:0] rsp;
        r_ok = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        while (!r_ok) begin
            @(negedge aclk);
            ar_ok = s_axi_arvalid && s_axi_arready;
            r_ok = s_axi_rvalid && s_axi_rready;
            v = s_axi_rvalid;
            dat = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
            if (!r_ok) s_axi_rready <= v;
        end
        s_axi_rready <= 1'b0;
        chk($sformatf("reg %h", idx), {16'h0, e}, dat);
        chk_resp("rresp", er, rsp);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================
    // Test sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(PDR_IDX_BACKOFF, 16'h8020);
        rd(PDR_IDX_REGULATOR, 16'h0000);
        rd(PDR_IDX_LINE_DIAG, 16'h0001);
        rd(PDR_IDX_DIAG_MAIN, 16'h0e00);
        rd(PDR_IDX_DIAG_PULSE, 16'hc85c);
        rd(PDR_IDX_DIAG_LENGTH, 16'hffff);
        rd(PDR_IDX_DIAG_THRESH, 16'h1896);
        chk("cfg", {7'h0, 1'b1, 1'b0, 3'h6, 3'h1, 4'hc, 8'hff, 5'h18}, diag_cfg);
        // Every back-off code; reserved ones leave the level alone
        for (int c = 0; c < 8; c++) begin
            wr(PDR_IDX_BACKOFF, 16'(c << 6));
            rd(PDR_IDX_BACKOFF, 16'h8020 | 16'((c < 4 ? c : 3) << 6));
            chk("backoff_level", c < 4 ? c : 3, {29'h0, backoff_level});
        end
        // Regulator powers down on one pulse only, and never on a zero
        wr(PDR_IDX_REGULATOR, 16'h0000);
        chk("pd pulses", 0, pd_cnt);
        chk("off cycles", 0, off_cnt);
        wr(PDR_IDX_REGULATOR, 16'h8000);
        rd(PDR_IDX_REGULATOR, 16'h0000);
        chk("pd pulses", 1, pd_cnt);
        chk("off cycles", 1, off_cnt);
        chk("reg enable", 1, {31'h0, regulator_enable});
        // Main control with read-only bits and depth code 7 written
        wr(PDR_IDX_DIAG_MAIN, 16'hffff);
        rd(PDR_IDX_DIAG_MAIN, 16'h6e00);
        chk("cross_en", 0, {31'h0, diag_cfg.cross_en});
        chk("tx_bypass", 1, {31'h0, diag_cfg.tx_bypass});
        wr(PDR_IDX_DIAG_MAIN, 16'h2b00);
        rd(PDR_IDX_DIAG_MAIN, 16'h2b00);
        // Pulse, length and threshold words reach their fields
        wr(PDR_IDX_DIAG_PULSE, 16'h1235);
        rd(PDR_IDX_DIAG_PULSE, 16'h1235);
        wr(PDR_IDX_DIAG_LENGTH, 16'h3c5a);
        rd(PDR_IDX_DIAG_LENGTH, 16'h3c5a);
        wr(PDR_IDX_DIAG_THRESH, 16'h47e1);
        rd(PDR_IDX_DIAG_THRESH, 16'h47e1);
        chk("cfg", {7'h0, 1'b1, 1'b1, 3'h3, 3'h1, 4'h5, 8'h3c, 5'h07}, diag_cfg);
        // Upper lane only: the low byte of the length word must survive
        s_axi_wstrb <= 4'h2;
        wr(PDR_IDX_DIAG_LENGTH, 16'h0000);
        s_axi_wstrb <= 4'hf;
        rd(PDR_IDX_DIAG_LENGTH, 16'h005a);
        // Averaging factor beside read-only bits written high
        wr(PDR_IDX_LINE_DIAG, 16'h7ffd);
        rd(PDR_IDX_LINE_DIAG, 16'h0005);
        // One launch with the transmit pair bypassed; the count is read a bus access later
        wr(PDR_IDX_LINE_DIAG, 16'h8005);
        rd(PDR_IDX_LINE_DIAG, 16'h1005);
        chk("starts", 1, st_cnt);
        diag_res <= '{done: 1'b1, line_diag_result_field: 8'ha5};
        @(posedge aclk);
        diag_res.done <= 1'b0;
        rd(PDR_IDX_DIAG_STATUS, 16'h0002);
        rd(PDR_IDX_LINE_DIAG, 16'h1a55);
        // Reset after the run has finished brings back the defaults and clears the done state
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(PDR_IDX_BACKOFF, 16'h8020);
        rd(PDR_IDX_DIAG_MAIN, 16'h0e00);
        rd(PDR_IDX_DIAG_LENGTH, 16'hffff);
        rd(PDR_IDX_DIAG_STATUS, 16'h0000);
        rd(PDR_IDX_LINE_DIAG, 16'h0a51);
        // Unmapped place answers with an error and zero data
        wr(10'h001, 16'hffff, PDR_RESP_SLVERR);
        rd(10'h001, 16'h0000, PDR_RESP_SLVERR);
        end_sim;
    end
    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge aclk);
        fail_count++;
        end_sim;
    end
endmodule // phy_power_and_cable_diag_regs_tb

bind pdr_regs pdr_regs_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .backoff_level, .regulator_powerdown_bit,
    .regulator_enable, .diag_cfg, .diag_start);
